// ### hw/scmw_top.sv
/*
 * system clock mode and fast wake-up controller with an avalon-mm slave.
 * assumes halt_in comes from the cpu on ref_clk_in; wake and oscillator
 * ticks are asynchronous pins, each oscillator slower than half ref_clk_in.
 */
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps

// Summary of operation
// R1: fast wake runs cpu on sub clock
// R2: low ready low in deep stop, 128/2 cycles
// R3: high ready cleared at power-on, set when stable
// R4: high ready low in sleep, 512/16 cycles
// R5: halt enters idle or sleep by idle_select
// R6: idle keeps sysclk only with idle_clock_keep
// R7: high_clock_select picks undivided or divided/sub clock
// R8: moving to sub clock stops high oscillator
// R9: fast wake only from stop_keep_sub or idle_no_sysclk; code also allows it after PM_IDLE_WITH_SYSCLK while high ready is low
// R10: crystal fast wake switches after 512 cycles
// R11: rc high oscillator ignores fast_wake_en
// R12: watchdog off means no fast wake from deep stop
// R13: modes switch by selects, sleep only by halt
// R14: sub clock stops divide-by-16/64 clocks
// R15: slow mode for select zero and divider 000/001
// R16: slow mode waits for low_osc_ready
// R17: clk_div_select encodes sub clock and divisions
// R18: fast_wake_en is mode bit 4
// R19: writes to ready flags are ignored
module scmw_top (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic halt_in,
	input wire logic wake_in,
	input wire logic hi_osc_tick_in,
	input wire logic lo_osc_tick_in,
	output logic hi_osc_en_out,
	output logic lo_osc_en_out,
	output logic fh_div_clk_en_out,
	output logic [1:0] sys_clk_sel_out,
	output logic [2:0] sys_clk_div_out,
	output logic sys_clk_run_out,
	output logic cpu_run_out,
	output logic [2:0] power_mode_out
);

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		scmw_pkg::scmw_pmode_t mode;
		logic from_deep;
		logic fwe;
		logic idle_sel;
		logic hsel;
		logic [2:0] div;
		logic hrdy;
		logic lrdy;
		logic keep;
		logic hi_xtal;
		logic lo_xtal;
		logic wdt_on;
		logic [9:0] hcnt;
		logic [7:0] lcnt;
		logic [2:0] hsync;
		logic [2:0] lsync;
		logic [1:0] wsync;
		logic wreq;
		logic [7:0] rdata;
		logic hosc_en;
		logic losc_en;
		logic cpu_run;
		logic clk_run;
		logic [1:0] csel;
	} scmw_state_t;

	scmw_state_t st_r;
	scmw_state_t st_nxt;

	function automatic logic sub_req(input logic hsel, input logic [2:0] div);
		sub_req = !hsel && (div <= scmw_pkg::DIV_SUB_MAX); // R15 R17
	endfunction : sub_req

	function automatic logic is_stopped(input scmw_pkg::scmw_pmode_t m);
		is_stopped = (m == scmw_pkg::PM_DEEP_STOP) || (m == scmw_pkg::PM_STOP_KEEP_SUB) ||
			(m == scmw_pkg::PM_IDLE_NO_SYSCLK);
	endfunction : is_stopped

	logic hi_tick;
	logic lo_tick;
	logic wake;
	logic want_sub;
	logic acc_ok;
	assign hi_tick = st_r.hsync[1] && !st_r.hsync[2];
	assign lo_tick = st_r.lsync[1] && !st_r.lsync[2];
	assign wake = st_r.wsync[1];
	assign want_sub = sub_req(st_r.hsel, st_r.div);
	assign acc_ok = !st_r.wreq && (avs_read_in || avs_write_in);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		// pins pass two flops; third stage only feeds edge detection
		st_nxt.hsync = {st_r.hsync[1:0], hi_osc_tick_in};
		st_nxt.lsync = {st_r.lsync[1:0], lo_osc_tick_in};
		st_nxt.wsync = {st_r.wsync[0], wake_in};

		// bus: one wait state, then the access completes
		st_nxt.wreq = 1'b1;
		if (st_r.wreq && (avs_read_in || avs_write_in)) begin
			st_nxt.wreq = 1'b0;
			unique case (avs_address_in)
				scmw_pkg::ADDR_MODE: st_nxt.rdata = {st_r.div, st_r.fwe, st_r.lrdy, st_r.hrdy, st_r.idle_sel, st_r.hsel};
				scmw_pkg::ADDR_CTRL: st_nxt.rdata = {4'h0, st_r.wdt_on, st_r.lo_xtal, st_r.hi_xtal, st_r.keep};
				scmw_pkg::ADDR_STAT: st_nxt.rdata = {5'h00, 3'(st_r.mode)};
				default: st_nxt.rdata = 8'h00;
			endcase
		end
		if (acc_ok && avs_write_in) begin
			if (avs_address_in == scmw_pkg::ADDR_MODE) begin
				// ready flags are not writable
				st_nxt.div = avs_writedata_in[scmw_pkg::DIV_LSB +: 3]; // R19 R17
				st_nxt.fwe = avs_writedata_in[scmw_pkg::FWE_BIT]; // R18
				st_nxt.idle_sel = avs_writedata_in[scmw_pkg::IDLE_BIT];
				st_nxt.hsel = avs_writedata_in[scmw_pkg::HSEL_BIT];
			end
			if (avs_address_in == scmw_pkg::ADDR_CTRL) begin
				st_nxt.keep = avs_writedata_in[scmw_pkg::KEEP_BIT];
				st_nxt.hi_xtal = avs_writedata_in[scmw_pkg::HXTAL_BIT];
				st_nxt.lo_xtal = avs_writedata_in[scmw_pkg::LXTAL_BIT];
				st_nxt.wdt_on = avs_writedata_in[scmw_pkg::WDT_BIT];
			end
		end

		// stabilisation counters; a stopped oscillator loses its ready flag
		if (!st_r.hosc_en) begin
			st_nxt.hrdy = 1'b0; // R3 R4
			st_nxt.hcnt = 10'h000;
		end else if (!st_r.hrdy && hi_tick) begin
			if (st_r.hcnt == (st_r.hi_xtal ? scmw_pkg::HI_XTAL_CYC : scmw_pkg::HI_RC_CYC) - 10'h001) begin
				st_nxt.hrdy = 1'b1; // R4 R10
			end else begin
				st_nxt.hcnt = st_r.hcnt + 10'h001;
			end
		end
		if (!st_r.losc_en) begin
			st_nxt.lrdy = 1'b0; // R2
			st_nxt.lcnt = 8'h00;
		end else if (!st_r.lrdy && lo_tick) begin
			if (st_r.lcnt == (st_r.lo_xtal ? scmw_pkg::LO_XTAL_CYC : scmw_pkg::LO_RC_CYC) - 8'h01) begin
				st_nxt.lrdy = 1'b1; // R2
			end else begin
				st_nxt.lcnt = st_r.lcnt + 8'h01;
			end
		end

		// operating mode sequencing
		unique case (st_r.mode)
			scmw_pkg::PM_NORMAL, scmw_pkg::PM_SLOW, scmw_pkg::PM_FAST_WAKE: begin
				if (halt_in) begin
					if (st_r.idle_sel) begin // R5
						st_nxt.mode = st_r.keep ? scmw_pkg::PM_IDLE_WITH_SYSCLK : scmw_pkg::PM_IDLE_NO_SYSCLK; // R6
					end else begin
						st_nxt.mode = st_r.wdt_on ? scmw_pkg::PM_STOP_KEEP_SUB : scmw_pkg::PM_DEEP_STOP; // R12
					end
				end else if (st_r.mode == scmw_pkg::PM_FAST_WAKE) begin
					if (st_r.hrdy) begin
						st_nxt.mode = scmw_pkg::PM_NORMAL; // R10
					end
				end else if (want_sub && st_r.lrdy) begin
					st_nxt.mode = scmw_pkg::PM_SLOW; // R13 R16
				end else if (!want_sub && st_r.hrdy) begin
					st_nxt.mode = scmw_pkg::PM_NORMAL; // R13
				end
			end
			scmw_pkg::PM_IDLE_WITH_SYSCLK: begin
				if (wake) begin
					st_nxt.mode = (want_sub && st_r.lrdy) ? scmw_pkg::PM_SLOW : scmw_pkg::PM_WAKE_WAIT;
					st_nxt.from_deep = 1'b0;
				end
			end
			scmw_pkg::PM_DEEP_STOP, scmw_pkg::PM_STOP_KEEP_SUB, scmw_pkg::PM_IDLE_NO_SYSCLK: begin
				if (wake) begin
					st_nxt.mode = scmw_pkg::PM_WAKE_WAIT;
					st_nxt.from_deep = (st_r.mode == scmw_pkg::PM_DEEP_STOP); // R9
				end
			end
			scmw_pkg::PM_WAKE_WAIT: begin
				if (want_sub) begin
					if (st_r.lrdy) begin
						st_nxt.mode = scmw_pkg::PM_SLOW; // R16
					end
				end else if (st_r.hrdy) begin
					st_nxt.mode = scmw_pkg::PM_NORMAL; // R11
				end else if (st_r.fwe && st_r.hi_xtal && !st_r.from_deep && st_r.lrdy && lo_tick) begin
					st_nxt.mode = scmw_pkg::PM_FAST_WAKE; // R1 R9 R11
				end
			end
		endcase

		// oscillator enables and clock routing follow the next mode
		st_nxt.losc_en = (st_nxt.mode != scmw_pkg::PM_DEEP_STOP); // R12
		unique case (st_nxt.mode)
			scmw_pkg::PM_NORMAL, scmw_pkg::PM_FAST_WAKE: st_nxt.hosc_en = 1'b1;
			scmw_pkg::PM_SLOW, scmw_pkg::PM_WAKE_WAIT, scmw_pkg::PM_IDLE_WITH_SYSCLK:
				st_nxt.hosc_en = !sub_req(st_nxt.hsel, st_nxt.div); // R8 R14
			default: st_nxt.hosc_en = 1'b0; // R4
		endcase
		st_nxt.cpu_run = (st_nxt.mode == scmw_pkg::PM_NORMAL) || (st_nxt.mode == scmw_pkg::PM_SLOW) ||
			(st_nxt.mode == scmw_pkg::PM_FAST_WAKE);
		st_nxt.clk_run = st_nxt.cpu_run || (st_nxt.mode == scmw_pkg::PM_IDLE_WITH_SYSCLK); // R6
		if ((st_nxt.mode == scmw_pkg::PM_SLOW) || (st_nxt.mode == scmw_pkg::PM_FAST_WAKE)) begin
			st_nxt.csel = scmw_pkg::CSEL_SUB; // R1 R15
		end else if (st_nxt.hsel || sub_req(st_nxt.hsel, st_nxt.div)) begin
			// undivided clock selected, or sub clock pending its ready flag: stay on the high clock
			st_nxt.csel = scmw_pkg::CSEL_HIGH; // R7
		end else begin
			st_nxt.csel = scmw_pkg::CSEL_DIV; // R7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_r <= '0;
			// power-on waits on the high oscillator before the cpu runs
			st_r.mode <= scmw_pkg::PM_WAKE_WAIT; // R3
			st_r.from_deep <= 1'b1;
			st_r.div <= scmw_pkg::MODE_RST[scmw_pkg::DIV_LSB +: 3];
			st_r.fwe <= scmw_pkg::MODE_RST[scmw_pkg::FWE_BIT];
			st_r.idle_sel <= scmw_pkg::MODE_RST[scmw_pkg::IDLE_BIT];
			st_r.hsel <= scmw_pkg::MODE_RST[scmw_pkg::HSEL_BIT];
			st_r.keep <= scmw_pkg::CTRL_RST[scmw_pkg::KEEP_BIT];
			st_r.hi_xtal <= scmw_pkg::CTRL_RST[scmw_pkg::HXTAL_BIT];
			st_r.lo_xtal <= scmw_pkg::CTRL_RST[scmw_pkg::LXTAL_BIT];
			st_r.wdt_on <= scmw_pkg::CTRL_RST[scmw_pkg::WDT_BIT];
			st_r.wreq <= 1'b1;
			st_r.hosc_en <= 1'b1;
			st_r.losc_en <= 1'b1;
			st_r.csel <= scmw_pkg::CSEL_HIGH;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata_out = {24'h000000, st_r.rdata};
	assign avs_waitrequest_out = st_r.wreq;
	assign hi_osc_en_out = st_r.hosc_en;
	assign lo_osc_en_out = st_r.losc_en;
	assign fh_div_clk_en_out = st_r.hosc_en; // R14
	assign sys_clk_sel_out = st_r.csel;
	assign sys_clk_div_out = st_r.div;
	assign sys_clk_run_out = st_r.clk_run;
	assign cpu_run_out = st_r.cpu_run;
	assign power_mode_out = 3'(st_r.mode);

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	a_hrdy_low_stop: assert property (is_stopped(st_r.mode) && is_stopped($past(st_r.mode)) |-> !st_r.hrdy) // R4
		else $error("high ready set while stopped");
	a_lrdy_low_deep: assert property ((st_r.mode == scmw_pkg::PM_DEEP_STOP) ##1
		(st_r.mode == scmw_pkg::PM_DEEP_STOP) |-> !st_r.lrdy) // R2
		else $error("low ready set in deep stop");
	a_hrdy_xtal_count: assert property ($rose(st_r.hrdy) && st_r.hi_xtal |-> $past(st_r.hcnt) == 10'h1ff) // R4
		else $error("high ready rose at wrong count");
	a_halt_to_idle: assert property ((st_r.mode == scmw_pkg::PM_NORMAL) && halt_in && st_r.idle_sel |=>
		(st_r.mode == scmw_pkg::PM_IDLE_NO_SYSCLK) || (st_r.mode == scmw_pkg::PM_IDLE_WITH_SYSCLK)) // R5
		else $error("halt did not enter idle");
	a_idle_clk_keep: assert property ((st_r.mode == scmw_pkg::PM_NORMAL) && halt_in && st_r.idle_sel |=>
		!cpu_run_out && (sys_clk_run_out == $past(st_r.keep))) // R6
		else $error("idle clock state wrong");
	a_slow_needs_lrdy: assert property ((st_r.mode == scmw_pkg::PM_SLOW) && ($past(st_r.mode) != scmw_pkg::PM_SLOW)
		|-> st_r.lrdy && (sys_clk_sel_out == scmw_pkg::CSEL_SUB)) // R16
		else $error("slow entered before low ready");
	a_sub_stops_high: assert property ((st_r.mode == scmw_pkg::PM_SLOW) && want_sub
		|-> !hi_osc_en_out && !fh_div_clk_en_out) // R8
		else $error("high oscillator left on in slow");
	a_fast_not_deep: assert property ((st_r.mode == scmw_pkg::PM_FAST_WAKE) && ($past(st_r.mode) ==
		scmw_pkg::PM_WAKE_WAIT) |-> !st_r.from_deep && st_r.hi_xtal && st_r.fwe) // R9
		else $error("fast wake from deep stop or rc");
	a_fast_to_xtal: assert property ((st_r.mode == scmw_pkg::PM_FAST_WAKE) && st_r.hrdy && !halt_in
		|=> (st_r.mode == scmw_pkg::PM_NORMAL)) // R10
		else $error("fast wake did not switch to crystal");
	a_fwe_write: assert property (acc_ok && avs_write_in && (avs_address_in == scmw_pkg::ADDR_MODE)
		|=> st_r.fwe == $past(avs_writedata_in[scmw_pkg::FWE_BIT])) // R18
		else $error("fast wake enable not written");

endmodule : scmw_top

// ### inc/scmw_pkg.sv
/*
 * constants and types for the system clock mode and fast wake-up controller.
 * assumes a single 20 MHz register clock; oscillator ticks arrive as pins.
 */
package scmw_pkg;
	// register byte offsets on the avalon slave
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CTRL = 4'h4;
	localparam logic [3:0] ADDR_STAT = 4'h8;
	// system_mode_control field positions
	localparam int HSEL_BIT = 0;
	localparam int IDLE_BIT = 1;
	localparam int HRDY_BIT = 2;
	localparam int LRDY_BIT = 3;
	localparam int FWE_BIT = 4;
	localparam int DIV_LSB = 5;
	// control register field positions
	localparam int KEEP_BIT = 0;
	localparam int HXTAL_BIT = 1;
	localparam int LXTAL_BIT = 2;
	localparam int WDT_BIT = 3;
	// values after reset
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [7:0] CTRL_RST = 8'h0a;
	// stabilisation counts in oscillator cycles
	localparam logic [9:0] HI_XTAL_CYC = 10'h200;
	localparam logic [9:0] HI_RC_CYC = 10'h010;
	localparam logic [7:0] LO_XTAL_CYC = 8'h80;
	localparam logic [7:0] LO_RC_CYC = 8'h02;
	// divider codes at or below this select the sub clock
	localparam logic [2:0] DIV_SUB_MAX = 3'h1;
	// system clock source codes
	localparam logic [1:0] CSEL_HIGH = 2'h0;
	localparam logic [1:0] CSEL_DIV = 2'h1;
	localparam logic [1:0] CSEL_SUB = 2'h2;

	typedef enum logic [2:0] {
		PM_NORMAL,
		PM_SLOW,
		PM_FAST_WAKE,
		PM_WAKE_WAIT,
		PM_DEEP_STOP,
		PM_STOP_KEEP_SUB,
		PM_IDLE_NO_SYSCLK,
		PM_IDLE_WITH_SYSCLK
	} scmw_pmode_t;
endpackage : scmw_pkg

// ### verif/scmw_top_test.sv
/*
 * self-checking bench for the clock mode and fast wake-up controller.
 * assumes scmw_pkg is compiled first; oscillator pins are toggled by the bench.
 */
`timescale 1ns/100ps
module scmw_top_test;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] avs_address_in = 4'h0;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h0;
	logic halt_in = 1'b0;
	logic wake_in = 1'b0;
	logic hi_osc_tick_in = 1'b0;
	logic lo_osc_tick_in = 1'b0;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic hi_osc_en_out, lo_osc_en_out, fh_div_clk_en_out, sys_clk_run_out, cpu_run_out;
	logic [1:0] sys_clk_sel_out;
	logic [2:0] sys_clk_div_out, power_mode_out;
	integer err_count = 0;
	integer n_checks = 0;
	integer seed = 97196;
	// bench model of the mode register and the ready flags
	integer m_mode, m_hr, m_lr, i;
	logic [31:0] q;
	always #25 ref_clk_in = ~ref_clk_in;
	scmw_top i_scmw_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .halt_in(halt_in),
		.wake_in(wake_in), .hi_osc_tick_in(hi_osc_tick_in), .lo_osc_tick_in(lo_osc_tick_in),
		.hi_osc_en_out(hi_osc_en_out), .lo_osc_en_out(lo_osc_en_out), .fh_div_clk_en_out(fh_div_clk_en_out),
		.sys_clk_sel_out(sys_clk_sel_out), .sys_clk_div_out(sys_clk_div_out), .sys_clk_run_out(sys_clk_run_out),
		.cpu_run_out(cpu_run_out), .power_mode_out(power_mode_out));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	// request held until the rising edge that samples waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		integer k;
		k = 0;
		@(posedge ref_clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		do begin
			@(posedge ref_clk_in);
			k++;
		end while (avs_waitrequest_out !== 1'b0 && k < 40);
		if (k >= 40) chk(32'h1, 32'h0);
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		// outputs launched by the completing edge are settled by the falling edge
		@(negedge ref_clk_in);
	endtask : bus
	task automatic wr_mode(input integer v);
		bus(1'b1, scmw_pkg::ADDR_MODE, v);
		m_mode = v;
	endtask : wr_mode
	task automatic rd_mode;
		bus(1'b0, scmw_pkg::ADDR_MODE, 32'h0);
		chk(q, {24'h0, m_mode[7:4], m_lr[0], m_hr[0], m_mode[1:0]});
	endtask : rd_mode
	// one oscillator cycle every four reference cycles, well under the 10 MHz limit
	task automatic ticks(input integer n, input logic hi, input logic lo);
		repeat (n) begin
			@(posedge ref_clk_in);
			hi_osc_tick_in <= hi;
			lo_osc_tick_in <= lo;
			repeat (2) @(posedge ref_clk_in);
			hi_osc_tick_in <= 1'b0;
			lo_osc_tick_in <= 1'b0;
			@(posedge ref_clk_in);
		end
		repeat (6) @(posedge ref_clk_in);
	endtask : ticks
	task automatic wait_pm(input logic [2:0] pm);
		integer k;
		k = 0;
		while (power_mode_out !== pm && k < 100) begin
			@(negedge ref_clk_in);
			k++;
		end
		chk({29'h0, power_mode_out}, {29'h0, pm});
	endtask : wait_pm
	task automatic halt_wake(input integer ctrl, input integer mode, input logic [2:0] pm);
		bus(1'b1, scmw_pkg::ADDR_CTRL, ctrl);
		wr_mode(mode);
		@(posedge ref_clk_in);
		halt_in <= 1'b1;
		@(posedge ref_clk_in);
		halt_in <= 1'b0;
		wait_pm(pm);
		chk({30'h0, cpu_run_out, sys_clk_run_out}, {31'h0, pm == 3'h7});
		chk({30'h0, hi_osc_en_out, lo_osc_en_out}, {30'h0, pm == 3'h7, pm != 3'h4});
		if (pm != 3'h7) m_hr = 0;
		if (pm == 3'h4) m_lr = 0;
		rd_mode();
		@(posedge ref_clk_in);
		wake_in <= 1'b1;
		wait_pm(3'h3);
		@(posedge ref_clk_in);
		wake_in <= 1'b0;
	endtask : halt_wake
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(50 * 60000);
		err_count++;
		close_out();
	end
	initial begin
		m_mode = 1;
		m_hr = 0;
		m_lr = 0;
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd_mode();
		bus(1'b0, scmw_pkg::ADDR_CTRL, 32'h0);
		chk(q, 32'h0a);
		bus(1'b1, 4'hc, 32'hff);
		bus(1'b0, 4'hc, 32'h0);
		chk(q, 32'h0);
		chk({31'h0, cpu_run_out}, 32'h0);
		ticks(128, 1'b1, 1'b1);
		m_lr = 1;
		ticks(384, 1'b1, 1'b0);
		m_hr = 1;
		wait_pm(3'h0);
		rd_mode();
		// random dividers with the undivided clock chosen, ones written to the read-only ready bits
		for (i = 0; i < 4; i++) begin
			wr_mode({$random(seed)} % 8 * 32 + 8'h0d);
			rd_mode();
			chk({27'h0, sys_clk_sel_out, sys_clk_div_out}, {27'h0, scmw_pkg::CSEL_HIGH, m_mode[7:5]});
		end
		for (i = 2; i < 8; i++) begin
			wr_mode(i * 32);
			wait_pm(3'h0);
			chk({27'h0, sys_clk_sel_out, sys_clk_div_out}, {27'h0, scmw_pkg::CSEL_DIV, i[2:0]});
		end
		wr_mode(32'h20);
		wait_pm(3'h1);
		chk({28'h0, sys_clk_sel_out, hi_osc_en_out, fh_div_clk_en_out}, {28'h0, scmw_pkg::CSEL_SUB, 2'b00});
		m_hr = 0;
		repeat (4) @(posedge ref_clk_in);
		rd_mode();
		wr_mode(32'h01);
		chk({31'h0, hi_osc_en_out}, 32'h1);
		ticks(512, 1'b1, 1'b0);
		m_hr = 1;
		wait_pm(3'h0);
		// idle without system clock, fast wake on the sub clock
		halt_wake(32'h0a, 32'h13, 3'h6);
		ticks(1, 1'b0, 1'b1);
		wait_pm(3'h2);
		chk({30'h0, sys_clk_sel_out}, {30'h0, scmw_pkg::CSEL_SUB});
		chk({31'h0, cpu_run_out}, 32'h1);
		ticks(511, 1'b1, 1'b0);
		chk({29'h0, power_mode_out}, 32'h2);
		ticks(1, 1'b1, 1'b0);
		m_hr = 1;
		wait_pm(3'h0);
		rd_mode();
		halt_wake(32'h0b, 32'h03, 3'h7);
		wait_pm(3'h0);
		// sleep with watchdog on keeps the sub clock, rc high oscillator ignores fast wake
		halt_wake(32'h08, 32'h11, 3'h5);
		ticks(15, 1'b1, 1'b1);
		chk({29'h0, power_mode_out}, 32'h3);
		ticks(1, 1'b1, 1'b0);
		m_hr = 1;
		wait_pm(3'h0);
		// deep stop: no sub clock, so no fast wake
		halt_wake(32'h02, 32'h11, 3'h4);
		chk({31'h0, lo_osc_en_out}, 32'h1);
		ticks(128, 1'b1, 1'b1);
		m_lr = 1;
		chk({29'h0, power_mode_out}, 32'h3);
		ticks(384, 1'b1, 1'b0);
		m_hr = 1;
		wait_pm(3'h0);
		rd_mode();
		close_out();
	end
endmodule : scmw_top_test
